/* hdl/psb_regs.v */
// Status, bypass-control and error-counter registers of a tri-speed copper
// transceiver, reached through the register port of the management front end.
// Assumes all event and status inputs are produced on ref_clk.
//
// Functional notes
// - Fast mode error flags latch, clear on read
// - Fast mode link and lock bits live
// - Gigabit error flags latch, clear on read
// - Gigabit link and lock bits live
// - Gigabit delimiter errors latch, clear on read
// - Gigabit carrier extension error latches, read clears
// - Gigabit crossover error shown in bit five
// - Non-compliant partner flag, detection disable bit
// - Transmit disable bit, resets to zero
// - Encoder, scrambler, descrambler bypass bits
// - Receive and transmit coding sublayer bypass
// - Skip link fail hold timer
// - Sticky crossover disable at forced speeds
// - Sticky pair swap correction disable under auto-negotiation
// - Sticky polarity correction disable
// - Parallel detect honours advertised ability
// - Pulse shaping filter disable
// - Sticky disable automatic gigabit next pages
// - Saturating receive error counter, clear on read
// - Saturating false carrier counter, clear on read
// - Sticky bits survive software reset when enabled
`timescale 1ns/1ns
`include "psb_map.vh"
module psb_regs (
   input  wire                   ref_clk,
   input  wire                   sys_rst,
   input  wire                   sw_rst,
   input  wire                   sticky_keep_en,
   input  wire [`PSB_ADDR_W-1:0] reg_addr,
   input  wire                   reg_rd,
   input  wire                   reg_wr,
   input  wire [`PSB_DATA_W-1:0] reg_wdata,
   output wire [`PSB_DATA_W-1:0] reg_rdata,
   input  wire                   fe_scr_lock,
   input  wire                   fe_link_up,
   input  wire                   fe_lock_err,
   input  wire                   fe_link_drop,
   input  wire                   fe_rx_err,
   input  wire                   fe_tx_err,
   input  wire                   fe_start_delim_err,
   input  wire                   fe_end_delim_err,
   input  wire                   gb_scr_lock,
   input  wire                   gb_link_up,
   input  wire                   gb_lock_err,
   input  wire                   gb_link_drop,
   input  wire                   gb_rx_err,
   input  wire                   gb_tx_err,
   input  wire                   gb_start_delim_err,
   input  wire                   gb_end_delim_err,
   input  wire                   gb_carrier_ext_err,
   input  wire                   gb_noncompliant,
   input  wire                   gb_mdix_err,
   input  wire                   rx_err_evt,
   input  wire                   false_carrier_evt,
   input  wire                   forced_10_100,
   input  wire                   aneg_en,
   output wire                   tx_off,
   output wire                   bypass_4b5b,
   output wire                   bypass_scr,
   output wire                   bypass_descr,
   output wire                   bypass_pcs_rx,
   output wire                   bypass_pcs_tx,
   output wire                   skip_link_fail_hold_timer,
   output wire                   auto_mdix_off,
   output wire                   pair_swap_fix_off,
   output wire                   polarity_fix_off,
   output wire                   pd_honour_adv,
   output wire                   pulse_shape_off,
   output wire                   np_auto_off,
   output wire                   noncompliant_det_en
);
   localparam [15:0] FE_MASK     = `PSB_FE_LATCH_MASK;
   localparam [15:0] GB_MASK     = `PSB_GB_LATCH_MASK;
   localparam [15:0] BY_RST      = `PSB_BYPASS_RST;
   localparam [15:0] BY_WR_MASK  = `PSB_BYPASS_WR_MASK;
   localparam [15:0] BY_STICKY   = `PSB_BYPASS_STICKY_MASK;

   wire        rd_fe;
   wire        rd_gb;
   wire        rd_rxc;
   wire        rd_fcc;
   wire        wr_by;
   wire [15:0] fe_evt;
   wire [15:0] gb_evt;
   wire [15:0] fe_lat;
   wire [15:0] gb_lat;
   wire [7:0]  rx_err_cnt;
   wire [7:0]  false_car_cnt;

   reg  [15:0] bypass_r;
   reg  [15:0] bypass_nxt;
   reg         gb_nc_r;
   reg         gb_mdix_r;
   reg  [15:0] rdata_r;
   reg  [15:0] rdata_nxt;
   reg  [13:0] ctrl_r;

   assign rd_fe  = reg_rd && (reg_addr == `PSB_OFF_FE_STATUS);
   assign rd_gb  = reg_rd && (reg_addr == `PSB_OFF_GB_STATUS2);
   assign rd_rxc = reg_rd && (reg_addr == `PSB_OFF_RX_ERR_CNT);
   assign rd_fcc = reg_rd && (reg_addr == `PSB_OFF_FALSE_CAR_CNT);
   assign wr_by  = reg_wr && (reg_addr == `PSB_OFF_BYPASS);

   // Event vectors placed at their status bit positions
   assign fe_evt = {1'b0, fe_lock_err, fe_link_drop, 1'b0,
                    fe_rx_err, fe_tx_err, fe_start_delim_err, fe_end_delim_err,
                    8'h00};
   assign gb_evt = {1'b0, gb_lock_err, gb_link_drop, 1'b0,
                    gb_rx_err, gb_tx_err, gb_start_delim_err, gb_end_delim_err,
                    gb_carrier_ext_err, 7'h00};

   // Latched status flags; a read clears, a same-cycle event sets again
   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_lat
         if (FE_MASK[i]) begin : g_fe
            reg fe_bit_r;
            always @(posedge ref_clk) begin
               if (sys_rst || sw_rst) begin
                  fe_bit_r <= 1'b0;
               end else begin
                  fe_bit_r <= (fe_bit_r & ~rd_fe) | fe_evt[i];
               end
            end
            assign fe_lat[i] = fe_bit_r;
         end else begin : g_fe_none
            assign fe_lat[i] = 1'b0;
         end
         if (GB_MASK[i]) begin : g_gb
            reg gb_bit_r;
            always @(posedge ref_clk) begin
               if (sys_rst || sw_rst) begin
                  gb_bit_r <= 1'b0;
               end else begin
                  gb_bit_r <= (gb_bit_r & ~rd_gb) | gb_evt[i];
               end
            end
            assign gb_lat[i] = gb_bit_r;
         end else begin : g_gb_none
            assign gb_lat[i] = 1'b0;
         end
      end
   endgenerate

   // Partner and crossover indications follow the detectors
   always @(posedge ref_clk) begin
      if (sys_rst || sw_rst) begin
         gb_nc_r   <= 1'b0;
         gb_mdix_r <= 1'b0;
      end else begin
         gb_nc_r   <= gb_noncompliant & ~bypass_r[`PSB_BY_NC_DET_OFF];
         gb_mdix_r <= gb_mdix_err;
      end
   end

   // Bypass control: write, software reset with sticky retention
   always @* begin
      bypass_nxt = bypass_r;
      if (sw_rst) begin
         if (sticky_keep_en) begin
            bypass_nxt = (bypass_r & BY_STICKY) | (BY_RST & ~BY_STICKY);
         end else begin
            bypass_nxt = BY_RST;
         end
      end else if (wr_by) begin
         // Reserved bits stay zero whatever is written
         bypass_nxt = reg_wdata & BY_WR_MASK;
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         bypass_r <= BY_RST;
      end else begin
         bypass_r <= bypass_nxt;
      end
   end

   // Control outputs are registered so the datapath sees glitch-free levels
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_r <= 14'h0000;
      end else begin
         ctrl_r[0]  <= bypass_r[`PSB_BY_TX_OFF];
         ctrl_r[1]  <= bypass_r[`PSB_BY_4B5B];
         ctrl_r[2]  <= bypass_r[`PSB_BY_SCR];
         ctrl_r[3]  <= bypass_r[`PSB_BY_DESCR];
         ctrl_r[4]  <= bypass_r[`PSB_BY_PCS_RX];
         ctrl_r[5]  <= bypass_r[`PSB_BY_PCS_TX];
         ctrl_r[6]  <= bypass_r[`PSB_BY_LINK_HOLD];
         ctrl_r[7]  <= bypass_r[`PSB_BY_MDIX_FORCED] & forced_10_100;
         ctrl_r[8]  <= bypass_r[`PSB_BY_PAIR_SWAP_OFF] & aneg_en;
         ctrl_r[9]  <= bypass_r[`PSB_BY_POLARITY_OFF];
         ctrl_r[10] <= bypass_r[`PSB_BY_PD_HONOUR];
         ctrl_r[11] <= bypass_r[`PSB_BY_PULSE_SHAPE_OFF];
         // Software takes over next pages after the base page
         ctrl_r[12] <= bypass_r[`PSB_BY_NP_AUTO_OFF];
         ctrl_r[13] <= ~bypass_r[`PSB_BY_NC_DET_OFF];
      end
   end

   assign tx_off                    = ctrl_r[0];
   assign bypass_4b5b               = ctrl_r[1];
   assign bypass_scr                = ctrl_r[2];
   assign bypass_descr              = ctrl_r[3];
   assign bypass_pcs_rx             = ctrl_r[4];
   assign bypass_pcs_tx             = ctrl_r[5];
   assign skip_link_fail_hold_timer = ctrl_r[6];
   assign auto_mdix_off             = ctrl_r[7];
   assign pair_swap_fix_off         = ctrl_r[8];
   assign polarity_fix_off          = ctrl_r[9];
   assign pd_honour_adv             = ctrl_r[10];
   assign pulse_shape_off           = ctrl_r[11];
   assign np_auto_off               = ctrl_r[12];
   assign noncompliant_det_en       = ctrl_r[13];

   // Error counters
   psb_sat_cnt #(
      .WIDTH (`PSB_CNT_W)
   ) u_rx_err_cnt (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .sw_rst  (sw_rst),
      .evt     (rx_err_evt),
      .rd_clr  (rd_rxc),
      .count   (rx_err_cnt)
   );

   psb_sat_cnt #(
      .WIDTH (`PSB_CNT_W)
   ) u_false_car_cnt (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .sw_rst  (sw_rst),
      .evt     (false_carrier_evt),
      .rd_clr  (rd_fcc),
      .count   (false_car_cnt)
   );

   // Read mux; the value before clearing is what the reader gets
   always @* begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            `PSB_OFF_FE_STATUS: begin
               rdata_nxt = fe_lat;
               rdata_nxt[`PSB_ST_SCR_LOCK] = fe_scr_lock;
               rdata_nxt[`PSB_ST_LINK_UP]  = fe_link_up;
            end
            `PSB_OFF_GB_STATUS2: begin
               rdata_nxt = gb_lat;
               rdata_nxt[`PSB_ST_SCR_LOCK]    = gb_scr_lock;
               rdata_nxt[`PSB_ST_LINK_UP]     = gb_link_up;
               rdata_nxt[`PSB_ST_NONCOMPLIANT] = gb_nc_r;
               rdata_nxt[`PSB_ST_MDIX_ERR]    = gb_mdix_r;
            end
            `PSB_OFF_BYPASS: begin
               rdata_nxt = bypass_r;
            end
            `PSB_OFF_RX_ERR_CNT: begin
               rdata_nxt = {8'h00, rx_err_cnt};
            end
            `PSB_OFF_FALSE_CAR_CNT: begin
               rdata_nxt = {8'h00, false_car_cnt};
            end
            default: begin
               // Other registers of the device are decoded elsewhere
               rdata_nxt = 16'h0000;
            end
         endcase
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
endmodule

/* hdl/psb_map.vh */
// Register offsets, field positions, reset values and masks of the PHY
// status, bypass-control and error-counter register group.
// Assumes a 5-bit register address from the serial management front end.
`ifndef PSB_MAP_VH
`define PSB_MAP_VH

// Register offsets
`define PSB_ADDR_W              5
`define PSB_DATA_W              16
`define PSB_OFF_FE_STATUS       5'h10
`define PSB_OFF_GB_STATUS2      5'h11
`define PSB_OFF_BYPASS          5'h12
`define PSB_OFF_RX_ERR_CNT      5'h13
`define PSB_OFF_FALSE_CAR_CNT   5'h14

// Status field positions (bits 15:8 both status registers, bits 7:5 gigabit only)
`define PSB_ST_SCR_LOCK         15
`define PSB_ST_LOCK_ERR         14
`define PSB_ST_LINK_DROP        13
`define PSB_ST_LINK_UP          12
`define PSB_ST_RX_ERR           11
`define PSB_ST_TX_ERR           10
`define PSB_ST_START_DELIM      9
`define PSB_ST_END_DELIM        8
`define PSB_ST_CARRIER_EXT      7
`define PSB_ST_NONCOMPLIANT     6
`define PSB_ST_MDIX_ERR         5

// Bits that latch until read
`define PSB_FE_LATCH_MASK       16'h6f00
`define PSB_GB_LATCH_MASK       16'h6f80

// Bypass control field positions
`define PSB_BY_TX_OFF           15
`define PSB_BY_4B5B             14
`define PSB_BY_SCR              13
`define PSB_BY_DESCR            12
`define PSB_BY_PCS_RX           11
`define PSB_BY_PCS_TX           10
`define PSB_BY_LINK_HOLD        9
`define PSB_BY_MDIX_FORCED      7
`define PSB_BY_NC_DET_OFF       6
`define PSB_BY_PAIR_SWAP_OFF    5
`define PSB_BY_POLARITY_OFF     4
`define PSB_BY_PD_HONOUR        3
`define PSB_BY_PULSE_SHAPE_OFF  2
`define PSB_BY_NP_AUTO_OFF      1

// Bypass control reset value, writable bits and sticky bits
`define PSB_BYPASS_RST          16'h0088
`define PSB_BYPASS_WR_MASK      16'hfefe
`define PSB_BYPASS_STICKY_MASK  16'h00fa

// Error counters
`define PSB_CNT_W               8

`endif

/* hdl/psb_sat_cnt.v */
// Saturating event counter that clears when its register is read.
// Assumes event and clear strobes come from logic on the same clock.
`timescale 1ns/1ns
module psb_sat_cnt #(
   parameter WIDTH = 8
) (
   input  wire             ref_clk,
   input  wire             sys_rst,
   input  wire             sw_rst,
   input  wire             evt,
   input  wire             rd_clr,
   output wire [WIDTH-1:0] count
);
   localparam [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
   localparam [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

   reg [WIDTH-1:0] count_r;
   reg [WIDTH-1:0] count_nxt;

   always @* begin
      count_nxt = count_r;
      if (rd_clr) begin
         // An event in the clearing cycle starts the new count
         count_nxt = evt ? CNT_ONE : {WIDTH{1'b0}};
      end else if (evt && (count_r != CNT_MAX)) begin
         count_nxt = count_r + CNT_ONE;
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst || sw_rst) begin
         count_r <= {WIDTH{1'b0}};
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count = count_r;
endmodule

/* verification/psb_regs_sva.sv */
// Concurrent checks on the status, bypass and counter register block.
// Assumes binding to psb_regs; sees only its ports, one clock domain.
`timescale 1ns/1ns
module psb_regs_sva (
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        sw_rst,
   input wire [4:0]  reg_addr,
   input wire        reg_rd,
   input wire        reg_wr,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata,
   input wire        fe_link_up,
   input wire        forced_10_100,
   input wire        aneg_en,
   input wire        tx_off,
   input wire        auto_mdix_off,
   input wire        pair_swap_fix_off,
   input wire        pd_honour_adv,
   input wire        noncompliant_det_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   fe_live_a: assert property (reg_rd && reg_addr == 5'h10 |=>
      reg_rdata[12] == $past(fe_link_up) && reg_rdata[7:0] == 8'h00)
      else $error("fast status live link bit wrong");
   cnt_upper_a: assert property (reg_rd && (reg_addr == 5'h13 || reg_addr == 5'h14) |=>
      reg_rdata[15:8] == 8'h00) else $error("counter upper byte not zero");
   tx_off_a: assert property (reg_wr && reg_addr == 5'h12 && !sw_rst |=>
      ##1 tx_off == $past(reg_wdata[15], 2)) else $error("transmit disable not written");
   pd_wr_a: assert property (reg_wr && reg_addr == 5'h12 && !sw_rst ##1 1'b1 |=>
      pd_honour_adv == $past(reg_wdata[3], 2)) else $error("parallel detect bit not written");
   rst_dflt_a: assert property ($fell(sys_rst) |=> pd_honour_adv &&
      noncompliant_det_en && !tx_off && auto_mdix_off == $past(forced_10_100))
      else $error("control outputs wrong after reset");
   mdix_forced_a: assert property (auto_mdix_off |-> $past(forced_10_100))
      else $error("crossover disabled without forced speed");
   pair_swap_a: assert property (pair_swap_fix_off |-> $past(aneg_en))
      else $error("pair swap disable without auto negotiation");
endmodule
bind psb_regs psb_regs_sva psb_regs_sva_inst (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .sw_rst(sw_rst), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .fe_link_up(fe_link_up), .forced_10_100(forced_10_100), .aneg_en(aneg_en),
   .tx_off(tx_off), .auto_mdix_off(auto_mdix_off), .pair_swap_fix_off(pair_swap_fix_off),
   .pd_honour_adv(pd_honour_adv), .noncompliant_det_en(noncompliant_det_en));

/* verification/psb_mgmt_model.sv */
// Management station model driving the register port.
// Assumes calls start at a rising ref_clk edge; each task ends on one.
`timescale 1ns/1ns
module psb_mgmt_model (
   input  wire        ref_clk,
   output reg  [4:0]  reg_addr,
   output reg         reg_rd,
   output reg         reg_wr,
   output reg  [15:0] reg_wdata,
   input  wire [15:0] reg_rdata
);
   // Only issues what the bench asks; next-page handling stays with the caller
   initial begin
      reg_addr = 5'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   task wr(input [4:0] a, input [15:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
         reg_wdata <= ~d;
         reg_addr <= ~a;
         // Let one edge pass so a following call never drives the address twice in a step
         @(posedge ref_clk);
      end
   endtask
   // Read data stands until the next read, so it is taken one edge later
   task rd(input [4:0] a, output [15:0] q);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         reg_addr <= ~a;
         @(posedge ref_clk);
         q = reg_rdata;
      end
   endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the status, bypass and counter registers.
// Assumes psb_regs, its map header and the management model are compiled.
`timescale 1ns/1ns
module tb_top;
   reg         ref_clk;
   reg         sys_rst;
   reg         sw_rst;
   reg         keep;
   reg  [7:0]  fe;
   reg  [10:0] gb;
   reg         rx_ev;
   reg         fc_ev;
   reg         forced;
   reg         aneg;
   wire [4:0]  reg_addr;
   wire        reg_rd;
   wire        reg_wr;
   wire [15:0] reg_wdata;
   wire [15:0] reg_rdata;
   wire [13:0] ctl;
   reg  [15:0] q;
   integer     n_mismatch;
   integer     compares;
   integer     i;
   psb_mgmt_model psb_mgmt_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // Status inputs packed in register bit order: fe is bits 15:8, gb bits 15:5
   psb_regs psb_regs_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .sw_rst(sw_rst),
      .sticky_keep_en(keep), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fe_scr_lock(fe[7]),
      .fe_lock_err(fe[6]), .fe_link_drop(fe[5]), .fe_link_up(fe[4]), .fe_rx_err(fe[3]),
      .fe_tx_err(fe[2]), .fe_start_delim_err(fe[1]), .fe_end_delim_err(fe[0]),
      .gb_scr_lock(gb[10]), .gb_lock_err(gb[9]), .gb_link_drop(gb[8]), .gb_link_up(gb[7]),
      .gb_rx_err(gb[6]), .gb_tx_err(gb[5]), .gb_start_delim_err(gb[4]),
      .gb_end_delim_err(gb[3]), .gb_carrier_ext_err(gb[2]), .gb_noncompliant(gb[1]),
      .gb_mdix_err(gb[0]), .rx_err_evt(rx_ev), .false_carrier_evt(fc_ev),
      .forced_10_100(forced), .aneg_en(aneg), .tx_off(ctl[13]), .bypass_4b5b(ctl[12]),
      .bypass_scr(ctl[11]), .bypass_descr(ctl[10]), .bypass_pcs_rx(ctl[9]),
      .bypass_pcs_tx(ctl[8]), .skip_link_fail_hold_timer(ctl[7]), .auto_mdix_off(ctl[6]),
      .pair_swap_fix_off(ctl[5]), .polarity_fix_off(ctl[4]), .pd_honour_adv(ctl[3]),
      .pulse_shape_off(ctl[2]), .np_auto_off(ctl[1]), .noncompliant_det_en(ctl[0]));
   always #2 ref_clk = ~ref_clk;
   task chk(input string nm, input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task rdc(input [4:0] a, input [15:0] e);
      begin
         psb_mgmt_model_inst.rd(a, q);
         chk($sformatf("reg %h", a), q, e);
      end
   endtask
   task tally_and_finish;
      begin
         $display("compares %0d n_mismatch %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // Whole run is about 375 cycles; over five times that is a hang
   initial begin
      #8000;
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
   end
   initial begin
      {ref_clk, sw_rst, keep, fe, gb, rx_ev, fc_ev, forced, aneg} = 0;
      sys_rst = 1'b1;
      n_mismatch = 0;
      compares = 0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (i = 16; i < 21; i = i + 1)
         rdc(i[4:0], (i == 18) ? 16'h0088 : 16'h0000);
      chk("ctl", {2'h0, ctl}, 16'h0009);
      fe <= 8'hff;
      @(posedge ref_clk);
      fe <= 8'h90;
      rdc(5'h10, 16'hff00);
      rdc(5'h10, 16'h9000);
      gb <= 11'h7ff;
      @(posedge ref_clk);
      gb <= 11'h483;
      rdc(5'h11, 16'hffe0);
      rdc(5'h11, 16'h9060);
      // Event lands in the cycle of the clearing read and must survive it
      fe <= 8'hd0;
      rdc(5'h10, 16'h9000);
      fe <= 8'h90;
      rdc(5'h10, 16'hd000);
      rx_ev <= 1'b1;
      repeat (300) @(posedge ref_clk);
      rdc(5'h13, 16'h00ff);
      rx_ev <= 1'b0;
      rdc(5'h13, 16'h0002);
      fc_ev <= 1'b1;
      repeat (5) @(posedge ref_clk);
      fc_ev <= 1'b0;
      rdc(5'h14, 16'h0005);
      forced <= 1'b1;
      aneg <= 1'b1;
      psb_mgmt_model_inst.wr(5'h12, 16'hffff);
      rdc(5'h12, 16'hfefe);
      chk("ctl", {2'h0, ctl}, 16'h3ffe);
      rdc(5'h11, 16'h9020);
      psb_mgmt_model_inst.wr(5'h13, 16'h00aa);
      rdc(5'h13, 16'h0000);
      rdc(5'h1f, 16'h0000);
      psb_mgmt_model_inst.wr(5'h12, 16'h0000);
      rdc(5'h12, 16'h0000);
      chk("ctl", {2'h0, ctl}, 16'h0001);
      psb_mgmt_model_inst.wr(5'h12, 16'hfefe);
      keep <= 1'b1;
      sw_rst <= 1'b1;
      @(posedge ref_clk);
      sw_rst <= 1'b0;
      rdc(5'h12, 16'h00fa);
      keep <= 1'b0;
      sw_rst <= 1'b1;
      @(posedge ref_clk);
      sw_rst <= 1'b0;
      rdc(5'h12, 16'h0088);
      tally_and_finish;
   end
endmodule
